/* File: hdl/cla_window.sv */
// Software access window into a sixteen-line prefetch cache, with hit lookup and
// pseudo-LRU replacement state.
// Assumes a classic Wishbone master on the same clock and an asynchronous
// code protection level on code_protect_i.
`timescale 1ns/10ps
// Operation
// - set alias sets written ones in control
// - invert alias toggles written ones in control
// - tag clear alias clears selected line bits
// - zero bits in aliases change nothing
// - aliases never touch reserved or read-only bits
// - alias reads return zero
// - tag register follows the selected line
// - boot select picks between two regions
// - tag compares physical address bits 23:4
// - only valid lines can hit
// - locked lines are never replacement victims
// - kind bit marks instruction lines, resets one
// - mask ones force a match per bit
// - mask writable only on lines A and B
// - mask register follows line, resets zero
// - four data words map the selected line
// - data reads blocked under code protection
// - read-only 25-bit replacement state, resets zero
// - four-bit index selects one of sixteen lines
// - line writes need the write enable bit
module cla_window (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic code_protect_i,
  input wire logic lookup_req_i,
  input wire logic [31:0] lookup_addr_i,
  output logic hit_o,
  output logic [3:0] hit_line_o,
  output logic [3:0] victim_line_o,
  output logic victim_ok_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [31:0] acc_q;
  logic [31:0] tag_q [16];
  logic [31:0] msk_q [16];
  logic [3:0][31:0] data_q [16];
  logic [24:0] lru_q;
  logic [24:0] lru_d;
  logic ack_q;
  logic [31:0] dat_q;
  logic prot_s1_q;
  logic prot_s2_q;
  logic hit_q;
  logic [3:0] hit_line_q;
  logic [3:0] victim_q;
  logic victim_ok_q;
  logic [15:0] match_vec;
  logic [15:0] valid_vec;
  logic [15:0] lock_vec;
  logic any_hit;
  logic [3:0] hit_idx_d;
  logic [3:0] victim_d;
  logic victim_ok_d;
  logic [2:0] grp_tree;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire req;
  wire wr_go;
  wire [7:0] off;
  wire [31:0] bmask;
  wire [3:0] idx;
  wire wen;
  cla_pkg::cla_op_t op;
  wire grp_acc;
  wire grp_tag;
  wire grp_msk;
  wire grp_dat;
  wire acc_wr;
  wire tag_wr;
  wire msk_wr;
  wire dat_wr;
  wire mask_line;
  wire [31:0] sel_tag;
  wire [31:0] sel_msk;
  wire [31:0] rd_data;

  assign req = cyc_i & stb_i;
  assign wr_go = req & ack_q & we_i;
  assign off = {adr_i[7:2], 2'b00};
  assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign idx = acc_q[3:0];
  assign wen = acc_q[cla_pkg::ACC_WEN_BIT];
  assign op = cla_pkg::cla_op_t'(off[3:2]);
  assign grp_acc = (off[7:4] == cla_pkg::OFF_ACC[7:4]);
  assign grp_tag = (off[7:4] == cla_pkg::OFF_TAG[7:4]);
  assign grp_msk = (off[7:4] == cla_pkg::OFF_MSK[7:4]);
  assign grp_dat = (off[7:4] == cla_pkg::OFF_WORD0[7:4]);
  assign mask_line = (idx == cla_pkg::MSK_LINE_A) | (idx == cla_pkg::MSK_LINE_B);
  assign acc_wr = wr_go & grp_acc & (op != cla_pkg::OP_CLR);
  assign tag_wr = wr_go & grp_tag & wen;
  assign msk_wr = wr_go & grp_msk & wen & mask_line;
  assign dat_wr = wr_go & grp_dat & wen;
  assign sel_tag = tag_q[idx];
  assign sel_msk = msk_q[idx];

  // Alias reads give zero; data words read zero under code protection.
  assign rd_data = (off == cla_pkg::OFF_ACC) ? acc_q :
                   (off == cla_pkg::OFF_TAG) ? sel_tag :
                   (off == cla_pkg::OFF_MSK) ? sel_msk :
                   grp_dat ? (prot_s2_q ? 32'h00000000 : data_q[idx][off[3:2]]) :
                   (off == cla_pkg::OFF_LRU) ? {7'h00, lru_q} :
                   32'h00000000;

  // ------------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        dat_q <= rd_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prot_s1_q <= 1'b1;
      prot_s2_q <= 1'b1;
    end else begin
      prot_s1_q <= code_protect_i;
      prot_s2_q <= prot_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // Control, tag and mask registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= cla_pkg::ACC_RST;
    end else if (acc_wr) begin
      acc_q <= cla_pkg::cla_alias_apply(acc_q, dat_i, bmask, cla_pkg::ACC_WR_MASK, op);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        tag_q[i] <= cla_pkg::TAG_RST;
        msk_q[i] <= cla_pkg::MSK_RST;
      end
    end else begin
      if (tag_wr) begin
        tag_q[idx] <= cla_pkg::cla_alias_apply(sel_tag, dat_i, bmask, cla_pkg::TAG_WR_MASK, op);
      end
      if (msk_wr) begin
        msk_q[idx] <= cla_pkg::cla_alias_apply(sel_msk, dat_i, bmask, cla_pkg::MSK_WR_MASK, op);
      end
    end
  end

  // Data array holds no reset; its contents are undefined until written.
  always_ff @(posedge clk_i) begin
    if (dat_wr) begin
      data_q[idx][off[3:2]] <= (data_q[idx][off[3:2]] & ~bmask) | (dat_i & bmask);
    end
  end

  // ------------------------------------------------------------------
  // Hit detection
  // ------------------------------------------------------------------
  generate
    for (genvar g = 0; g < 16; g++) begin : g_line
      cla_line_match u_match (
        .tag_i(tag_q[g]),
        .mask_i(msk_q[g]),
        .addr_i(lookup_addr_i),
        .match_o(match_vec[g])
      );
      assign valid_vec[g] = tag_q[g][cla_pkg::TAG_VALID_BIT];
      assign lock_vec[g] = tag_q[g][cla_pkg::TAG_LOCK_BIT];
    end
  endgenerate

  // Lowest matching line wins when masking makes several lines match.
  always_comb begin
    any_hit = 1'b0;
    hit_idx_d = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (match_vec[i]) begin
        any_hit = 1'b1;
        hit_idx_d = 4'(i);
      end
    end
  end

  // ------------------------------------------------------------------
  // Pseudo-LRU replacement
  // ------------------------------------------------------------------
  // Bits 2:0 form the tree over four groups; each group of four lines owns three bits.
  function automatic logic [1:0] plru_pick(input logic [2:0] t);
    plru_pick = {t[0], t[0] ? t[2] : t[1]};
  endfunction

  function automatic logic [2:0] plru_touch(input logic [2:0] t, input logic [1:0] w);
    logic [2:0] r;
    r = t;
    r[0] = ~w[1];
    if (w[1]) begin
      r[2] = ~w[0];
    end else begin
      r[1] = ~w[0];
    end
    plru_touch = r;
  endfunction

  always_comb begin
    lru_d = lru_q;
    if (lookup_req_i && any_hit) begin
      lru_d[2:0] = plru_touch(lru_q[2:0], hit_idx_d[3:2]);
      for (int g = 0; g < 4; g++) begin
        if (hit_idx_d[3:2] == 2'(g)) begin
          lru_d[3 + 3 * g +: 3] = plru_touch(lru_q[3 + 3 * g +: 3], hit_idx_d[1:0]);
        end
      end
    end
  end

  // Tree victim, falling back to the lowest unlocked line when the tree points at a locked one.
  always_comb begin
    grp_tree = 3'b000;
    for (int g = 0; g < 4; g++) begin
      if (plru_pick(lru_q[2:0]) == 2'(g)) begin
        grp_tree = lru_q[3 + 3 * g +: 3];
      end
    end
    victim_d = {plru_pick(lru_q[2:0]), plru_pick(grp_tree)};
    victim_ok_d = ~&lock_vec;
    if (lock_vec[victim_d]) begin
      for (int i = 15; i >= 0; i--) begin
        if (!lock_vec[i]) begin
          victim_d = 4'(i);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lru_q <= cla_pkg::LRU_RST;
      hit_q <= 1'b0;
      hit_line_q <= 4'h0;
      victim_q <= 4'h0;
      victim_ok_q <= 1'b0;
    end else begin
      lru_q <= lru_d;
      hit_q <= lookup_req_i & any_hit;
      hit_line_q <= hit_idx_d;
      victim_q <= victim_d;
      victim_ok_q <= victim_ok_d;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign hit_o = hit_q;
  assign hit_line_o = hit_line_q;
  assign victim_line_o = victim_q;
  assign victim_ok_o = victim_ok_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  acc_set_a: assert property (
    wr_go && off == cla_pkg::OFF_ACC_SET |=>
      acc_q == ($past(acc_q) | ($past(dat_i) & $past(bmask) & cla_pkg::ACC_WR_MASK)))
    else $error("control set alias did not set written ones");

  acc_inv_a: assert property (
    wr_go && off == cla_pkg::OFF_ACC_INV |=>
      acc_q == ($past(acc_q) ^ ($past(dat_i) & $past(bmask) & cla_pkg::ACC_WR_MASK)))
    else $error("control invert alias did not toggle written ones");

  tag_clr_a: assert property (
    wr_go && wen && off == cla_pkg::OFF_TAG_CLR |=>
      sel_tag == ($past(sel_tag) & ~($past(dat_i) & $past(bmask) & cla_pkg::TAG_WR_MASK)))
    else $error("tag clear alias result wrong");

  tag_set_a: assert property (
    wr_go && wen && off == cla_pkg::OFF_TAG_SET |=>
      sel_tag == ($past(sel_tag) | ($past(dat_i) & $past(bmask) & cla_pkg::TAG_WR_MASK)))
    else $error("tag set alias changed unwritten bits");

  reserved_a: assert property (
    (acc_q & ~cla_pkg::ACC_WR_MASK) == 32'h00000000 && (sel_tag & ~cla_pkg::TAG_WR_MASK) == 32'h00000000 &&
    (sel_msk & ~cla_pkg::MSK_WR_MASK) == 32'h00000000)
    else $error("reserved bit became set");

  line_wen_a: assert property (
    wr_go && !wen && (grp_tag || grp_msk || grp_dat) |=> $stable(sel_tag) && $stable(sel_msk))
    else $error("line changed without write enable");

  mask_line_a: assert property (
    wr_go && grp_msk && !mask_line |=> $stable(sel_msk))
    else $error("mask written on a line other than A or B");

  prot_read_a: assert property (
    req && !ack_q && !we_i && grp_dat && prot_s2_q |=> ack_o && dat_o == 32'h00000000)
    else $error("data word leaked under code protection");

  hit_valid_a: assert property (
    lookup_req_i && any_hit |-> valid_vec[hit_idx_d] ##1 (hit_o && hit_line_o == $past(hit_idx_d)))
    else $error("hit reported on an invalid line");

  victim_lock_a: assert property (
    victim_ok_d |-> !lock_vec[victim_d] ##1 (victim_ok_o && victim_line_o == $past(victim_d)))
    else $error("locked line chosen as victim");

  lru_ro_a: assert property (
    wr_go && off == cla_pkg::OFF_LRU && !lookup_req_i |=> $stable(lru_q))
    else $error("replacement state changed by a register write");

  bus_ack_a: assert property (
    req && !ack_q |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single cycle after request");

endmodule

/* File: hdl/cla_pkg.sv */
// Constants, register layout and alias helper for the cache line access window.
// Assumes a 32-bit classic Wishbone register bus with byte addresses on adr_i[7:0].
package cla_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_ACC = 8'h00;
  localparam logic [7:0] OFF_ACC_SET = 8'h08;
  localparam logic [7:0] OFF_ACC_INV = 8'h0C;
  localparam logic [7:0] OFF_TAG = 8'h10;
  localparam logic [7:0] OFF_TAG_CLR = 8'h14;
  localparam logic [7:0] OFF_TAG_SET = 8'h18;
  localparam logic [7:0] OFF_TAG_INV = 8'h1C;
  localparam logic [7:0] OFF_MSK = 8'h20;
  localparam logic [7:0] OFF_MSK_CLR = 8'h24;
  localparam logic [7:0] OFF_MSK_SET = 8'h28;
  localparam logic [7:0] OFF_MSK_INV = 8'h2C;
  localparam logic [7:0] OFF_WORD0 = 8'h30;
  localparam logic [7:0] OFF_WORD1 = 8'h34;
  localparam logic [7:0] OFF_WORD2 = 8'h38;
  localparam logic [7:0] OFF_WORD3 = 8'h3C;
  localparam logic [7:0] OFF_LRU = 8'h40;

  // ------------------------------------------------------------------
  // Field positions, writable masks and reset values
  // ------------------------------------------------------------------
  localparam int ACC_WEN_BIT = 31;
  localparam logic [31:0] ACC_WR_MASK = 32'h8000000F;
  localparam logic [31:0] ACC_RST = 32'h00000000;
  localparam int TAG_BOOT_BIT = 31;
  localparam int TAG_VALID_BIT = 3;
  localparam int TAG_LOCK_BIT = 2;
  localparam int TAG_KIND_BIT = 1;
  localparam logic [31:0] TAG_WR_MASK = 32'h80FFFFFE;
  localparam logic [31:0] TAG_RST = 32'h00000002;
  localparam logic [31:0] MSK_WR_MASK = 32'h0000FFE0;
  localparam logic [31:0] MSK_RST = 32'h00000000;
  localparam logic [3:0] MSK_LINE_A = 4'hA;
  localparam logic [3:0] MSK_LINE_B = 4'hB;
  localparam int LRU_W = 25;
  localparam logic [24:0] LRU_RST = 25'h0000000;
  localparam logic [31:0] REGION_ONE_BASE = 32'h1D000000;
  localparam logic [31:0] REGION_ZERO_BASE = 32'h1FC00000;

  // Offset bits [3:2] inside a group select the access kind.
  typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} cla_op_t;

  // Applies a plain, set, clear or invert write to the writable bits only.
  function automatic logic [31:0] cla_alias_apply(input logic [31:0] old, input logic [31:0] wd,
                                                  input logic [31:0] bm, input logic [31:0] wr_mask,
                                                  input cla_op_t op);
    logic [31:0] m;
    m = bm & wr_mask & wd;
    case (op)
      OP_SET: cla_alias_apply = old | m;
      OP_CLR: cla_alias_apply = old & ~m;
      OP_INV: cla_alias_apply = old ^ m;
      default: cla_alias_apply = (old & ~(bm & wr_mask)) | (wd & bm & wr_mask);
    endcase
  endfunction

endpackage

/* File: hdl/cla_line_match.sv */
// Hit comparator for one cache line.
// Assumes tag and mask words in register layout and a full 32-bit physical address.
`timescale 1ns/10ps
module cla_line_match (
  input wire logic [31:0] tag_i,
  input wire logic [31:0] mask_i,
  input wire logic [31:0] addr_i,
  output logic match_o
);

  // ------------------------------------------------------------------
  // Region, tag and mask compare
  // ------------------------------------------------------------------
  wire region_ok;
  wire [19:0] tag_diff;

  assign region_ok = tag_i[cla_pkg::TAG_BOOT_BIT] ?
                     (addr_i[31:24] == cla_pkg::REGION_ONE_BASE[31:24]) :
                     (addr_i[31:22] == cla_pkg::REGION_ZERO_BASE[31:22]);
  assign tag_diff = (tag_i[23:4] ^ addr_i[23:4]) & ~mask_i[23:4];
  assign match_o = tag_i[cla_pkg::TAG_VALID_BIT] & region_ok & ~|tag_diff;

endmodule

/* File: bench/cla_bus_master.sv */
// Bus master model standing in for the processor core on the register bus.
// Assumes a classic Wishbone slave on clk_i that always answers with ack_i.
`timescale 1ns/10ps
module cla_bus_master (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h00000000;
  end

  // One single cycle; released lines show the inverse so stale values cannot pass.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    adr_o <= ~a;
    sel_o <= 4'h0;
    dat_o <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h00000000, q);
  endtask
endmodule

/* File: bench/tb_cache_line_access_window.sv */
// Self-checking bench for the cache line access window.
// Assumes the window's register map and a bus master model on the same clock.
`timescale 1ns/10ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module tb_cache_line_access_window;
  logic clk_i, rst_i, cyc, stb, we, ack, code_protect, lookup_req, hit, victim_ok;
  logic [7:0] adr;
  logic [3:0] sel, hit_line, victim_line, idx;
  logic [31:0] wdat, rdat, lookup_addr, rd, v, t;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  cla_window dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .code_protect_i(code_protect), .lookup_req_i(lookup_req),
    .lookup_addr_i(lookup_addr), .hit_o(hit), .hit_line_o(hit_line), .victim_line_o(victim_line),
    .victim_ok_o(victim_ok));
  cla_bus_master bus (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] alias_fx(logic [31:0] old, logic [31:0] wd, logic [31:0] wm, int op);
    case (op)
      0: return (old & ~wm) | (wd & wm);
      1: return old & ~(wd & wm);
      2: return old | (wd & wm);
      default: return old ^ (wd & wm);
    endcase
  endfunction

  task automatic sel_line(input logic [3:0] i, input logic wen);
    bus.wr(cla_pkg::OFF_ACC, {wen, 27'h0, i});
  endtask

  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e, input string what);
    bus.rd(a, rd);
    `CHK(what, e, rd)
  endtask

  task automatic look(input logic [31:0] a, input logic eh, input logic [3:0] el, input string what);
    @(posedge clk_i);
    lookup_req <= 1'b1;
    lookup_addr <= a;
    @(posedge clk_i);
    lookup_req <= 1'b0;
    @(negedge clk_i);
    `CHK(what, eh, hit)
    if (eh) `CHK(what, el, hit_line)
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    code_protect = 1'b0;
    lookup_req = 1'b0;
    lookup_addr = 32'h00000000;
    void'($urandom(26));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    expect_rd(cla_pkg::OFF_ACC, 32'h00000000, "control reset");
    expect_rd(cla_pkg::OFF_TAG, 32'h00000002, "tag reset");
    expect_rd(cla_pkg::OFF_MSK, 32'h00000000, "mask reset");
    bus.wr(cla_pkg::OFF_LRU, 32'hFFFFFFFF);
    expect_rd(cla_pkg::OFF_LRU, 32'h00000000, "lru read only");
    bus.wr(cla_pkg::OFF_TAG, 32'h00FFFFF8);
    expect_rd(cla_pkg::OFF_TAG, 32'h00000002, "tag write disabled");
    $display("test reset values done");
    bus.wr(cla_pkg::OFF_ACC_SET, 32'hFFFFFFFF);
    expect_rd(cla_pkg::OFF_ACC, 32'h8000000F, "control set alias");
    bus.wr(cla_pkg::OFF_ACC_INV, 32'h8000000A);
    expect_rd(cla_pkg::OFF_ACC, 32'h00000005, "control invert alias");
    bus.rd(cla_pkg::OFF_ACC_SET, rd);
    $display("test control aliases done");
    for (int n = 0; n < 12; n++) begin
      idx = 4'($urandom_range(15, 0));
      sel_line(idx, 1'b1);
      v = $urandom() & 32'h80FFFFFE;
      bus.wr(cla_pkg::OFF_TAG, v);
      for (int op = 1; op < 4; op++) begin
        t = $urandom();
        bus.wr(cla_pkg::OFF_TAG + 8'(4 * op), t);
        v = alias_fx(v, t, 32'h80FFFFFE, op);
      end
      t = $urandom();
      bus.wr(cla_pkg::OFF_WORD0 + 8'(4 * (n % 4)), t);
      sel_line(idx ^ 4'h1, 1'b1);
      bus.wr(cla_pkg::OFF_TAG, 32'h00000002);
      sel_line(idx, 1'b1);
      expect_rd(cla_pkg::OFF_TAG, v, "line tag");
      expect_rd(cla_pkg::OFF_WORD0 + 8'(4 * (n % 4)), t, "data word");
    end
    for (int i = 0; i < 16; i++) begin
      sel_line(4'(i), 1'b1);
      bus.wr(cla_pkg::OFF_TAG, 32'h00000000);
    end
    $display("test random lines done");
    sel_line(4'h5, 1'b1);
    bus.wr(cla_pkg::OFF_MSK, 32'h0000FFE0);
    expect_rd(cla_pkg::OFF_MSK, 32'h00000000, "mask line five");
    sel_line(4'hA, 1'b1);
    bus.wr(cla_pkg::OFF_MSK_SET, 32'hFFFFFFFF);
    expect_rd(cla_pkg::OFF_MSK, 32'h0000FFE0, "mask line ten");
    bus.wr(cla_pkg::OFF_MSK_CLR, 32'h0000FFC0);
    expect_rd(cla_pkg::OFF_MSK, 32'h00000020, "mask clear alias");
    bus.wr(cla_pkg::OFF_MSK_INV, 32'h0000FFFF);
    expect_rd(cla_pkg::OFF_MSK, 32'h0000FFC0, "mask invert alias");
    bus.wr(cla_pkg::OFF_MSK_INV, 32'h0000FFE0);
    expect_rd(cla_pkg::OFF_MSK, 32'h00000020, "mask invert back");
    $display("test mask done");
    bus.wr(cla_pkg::OFF_TAG, 32'h80123458);
    look(32'h1D123450, 1'b1, 4'hA, "hit exact");
    look(32'h1D123470, 1'b1, 4'hA, "hit masked bit");
    look(32'h1D123460, 1'b0, 4'h0, "miss tag bit");
    sel_line(4'h3, 1'b1);
    bus.wr(cla_pkg::OFF_TAG, 32'h00C45678);
    look(32'h1FC45678, 1'b1, 4'h3, "hit boot zero");
    look(32'h1DC45678, 1'b0, 4'h0, "miss wrong region");
    bus.wr(cla_pkg::OFF_TAG_CLR, 32'h00000008);
    look(32'h1FC45678, 1'b0, 4'h0, "miss invalid");
    expect_rd(cla_pkg::OFF_LRU, 32'h00000807, "lru after hits");
    @(negedge clk_i);
    `CHK("tree victim allowed", 1'b1, victim_ok)
    `CHK("tree victim", 4'hC, victim_line)
    $display("test lookup done");
    t = $urandom();
    bus.wr(cla_pkg::OFF_WORD2, t);
    code_protect <= 1'b1;
    repeat (3) @(posedge clk_i);
    expect_rd(cla_pkg::OFF_WORD2, 32'h00000000, "protected read");
    code_protect <= 1'b0;
    repeat (3) @(posedge clk_i);
    expect_rd(cla_pkg::OFF_WORD2, t, "unprotected read");
    $display("test protection done");
    for (int i = 0; i < 16; i++) begin
      sel_line(4'(i), 1'b1);
      bus.wr(cla_pkg::OFF_TAG_SET, 32'h00000004);
    end
    look(32'h00000000, 1'b0, 4'h0, "miss all locked");
    `CHK("victim allowed", 1'b0, victim_ok)
    sel_line(4'h7, 1'b1);
    bus.wr(cla_pkg::OFF_TAG_CLR, 32'h00000004);
    look(32'h00000000, 1'b0, 4'h0, "miss one free");
    `CHK("victim allowed", 1'b1, victim_ok)
    `CHK("victim line", 4'h7, victim_line)
    $display("test replacement done");
    report_and_stop();
  end
endmodule
